// ===== src/dfs_pkg.sv
package dfs_pkg;
  localparam int CLK_HZ = 25000000;
  localparam int OP_TIME_US = 50;
  localparam int STB_TIME_MS = 130;
  localparam int STU_TIME_US = 12;
  localparam int OP_CYCLES = (OP_TIME_US * (CLK_HZ / 1000000));
  localparam int STB_CYCLES = (STB_TIME_MS * (CLK_HZ / 1000));
  localparam int STU_CYCLES = (STU_TIME_US * (CLK_HZ / 1000000));
  localparam int CNT_W = 23;
  localparam int STEP_CYCLES = 4;
  localparam logic [1:0] NUM_CHECKS = 2'h2;
  typedef enum logic [1:0] {DFS_IDLE, DFS_OPERATE, DFS_STANDBY} dfs_state_t;
endpackage

// ===== src/dfs_phase_timer.sv
`timescale 1ns/10ps
module dfs_phase_timer (
  input wire logic mclk,
  input wire logic srst,
  input wire logic start,
  input wire logic [22:0] load,
  output logic done
);
  logic [22:0] cnt_q;
  logic run_q;

  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      cnt_q <= 23'h0;
      run_q <= 1'b0;
      done <= 1'b0;
    end
    else
    begin
      done <= 1'b0;
      if (start)
      begin
        cnt_q <= load;
        run_q <= 1'b1;
      end
      else if (run_q)
      begin
        if (cnt_q <= 23'h1)
        begin
          run_q <= 1'b0;
          done <= 1'b1;
        end
        else
          cnt_q <= cnt_q - 23'h1;
      end
    end
  end
endmodule

// ===== src/dfs_seq.sv
`timescale 1ns/10ps
module dfs_seq #(
  parameter int STB_CYCLES = dfs_pkg::STB_CYCLES
) (
  input wire logic mclk,
  input wire logic srst,
  input wire logic supply_ok,
  input wire logic polarity_select,
  input wire logic op_south,
  input wire logic op_north,
  input wire logic rel_south,
  input wire logic rel_north,
  output logic sense_en,
  output logic q_o,
  output logic q_oe_n,
  output logic q_valid,
  output logic standby
);
  dfs_pkg::dfs_state_t state_q;
  logic tmr_start;
  logic [22:0] tmr_load;
  logic tmr_done;
  logic [1:0] check_q;
  logic [1:0] step_q;
  logic switched_q;
  logic decided_q;
  logic latched_q;
  logic slow_q;
  logic [9:0] rise_q;
  logic [1:0] ops_q;
  logic latch_q;

  dfs_phase_timer u_tmr (
    .mclk(mclk),
    .srst(srst),
    .start(tmr_start),
    .load(tmr_load),
    .done(tmr_done)
  );

  always_comb
  begin
    tmr_start = 1'b0;
    // timer runs load plus one cycles, so load one short of the phase length
    tmr_load = 23'(dfs_pkg::OP_CYCLES - 1);
    if (state_q == dfs_pkg::DFS_IDLE && supply_ok)
      tmr_start = 1'b1;
    else if (state_q == dfs_pkg::DFS_OPERATE && tmr_done)
    begin
      tmr_start = 1'b1;
      tmr_load = 23'(STB_CYCLES - 1);
    end
    else if (state_q == dfs_pkg::DFS_STANDBY && tmr_done)
      tmr_start = 1'b1;
  end

  // operate and standby alternate once supply is up
  always_ff @(posedge mclk)
  begin
    if (srst)
      state_q <= dfs_pkg::DFS_IDLE;
    else
    begin
      unique case (state_q)
        dfs_pkg::DFS_IDLE:
          if (supply_ok)
            state_q <= dfs_pkg::DFS_OPERATE;
        dfs_pkg::DFS_OPERATE:
          if (tmr_done)
            state_q <= dfs_pkg::DFS_STANDBY;
        dfs_pkg::DFS_STANDBY:
          if (tmr_done)
            state_q <= dfs_pkg::DFS_OPERATE;
        default:
          state_q <= dfs_pkg::DFS_IDLE;
      endcase
    end
  end

  // supply rise timing before first operate phase
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      rise_q <= 10'h0;
      slow_q <= 1'b0;
    end
    else if (state_q == dfs_pkg::DFS_IDLE && !supply_ok)
    begin
      if (rise_q >= 10'(dfs_pkg::STU_CYCLES))
        slow_q <= 1'b1;
      else
        rise_q <= rise_q + 10'h1;
    end
  end

  // sequential questioning: south then north
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      check_q <= 2'h0;
      step_q <= 2'h0;
      decided_q <= 1'b0;
    end
    else if (state_q != dfs_pkg::DFS_OPERATE)
    begin
      check_q <= 2'h0;
      step_q <= 2'h0;
      decided_q <= switched_q;
    end
    else if (check_q < dfs_pkg::NUM_CHECKS)
    begin
      step_q <= step_q + 2'h1;
      if (step_q == 2'(dfs_pkg::STEP_CYCLES - 1))
      begin
        check_q <= check_q + 2'h1;
        if (check_q == 2'h0)
        begin
          if (op_south)
            decided_q <= 1'b1;
          else if (rel_south && !switched_q)
            decided_q <= 1'b0;
          else
            decided_q <= switched_q;
        end
        else
        begin
          if (op_north)
            decided_q <= 1'b1;
          else if (rel_north && rel_south && !decided_q)
            decided_q <= 1'b0;
          else if (rel_north && rel_south)
            decided_q <= decided_q && op_south;
          else
            decided_q <= decided_q;
        end
      end
    end
  end

  // decision taken on the last operate cycle
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      latched_q <= 1'b0;
      switched_q <= 1'b0;
      ops_q <= 2'h0;
    end
    else if (state_q == dfs_pkg::DFS_OPERATE && tmr_done)
    begin
      latched_q <= decided_q;
      switched_q <= decided_q;
      if (ops_q != 2'h3)
        ops_q <= ops_q + 2'h1;
    end
  end

  // one-cycle strobe as standby begins; pin and valid move together
  always_ff @(posedge mclk)
  begin
    if (srst)
      latch_q <= 1'b0;
    else
      latch_q <= (state_q == dfs_pkg::DFS_OPERATE && tmr_done);
  end

  // slow rise: first decision drives the pin but does not raise q_valid
  always_ff @(posedge mclk)
  begin
    if (srst)
      q_valid <= 1'b0;
    else if (latch_q && (!slow_q || ops_q != 2'h1))
      q_valid <= 1'b1;
  end

  // phase flags, one cycle behind the state
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      sense_en <= 1'b0;
      standby <= 1'b0;
    end
    else
    begin
      sense_en <= (state_q == dfs_pkg::DFS_OPERATE);
      standby <= (state_q == dfs_pkg::DFS_STANDBY);
    end
  end

  // open drain: oe_n low means sinking; off state = released high
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      q_o <= 1'b0;
      q_oe_n <= 1'b1;
    end
    else
    begin
      q_o <= 1'b0;
      if (latch_q)
      begin
        if (polarity_select)
          q_oe_n <= !latched_q;
        else
          q_oe_n <= latched_q;
      end
    end
  end
endmodule

// ===== sim/dfs_seq_properties.sv
`timescale 1ns/10ps
module dfs_seq_properties #(
  parameter int STB_CYCLES = 200
) (
  input wire logic mclk,
  input wire logic srst,
  input wire logic sense_en,
  input wire logic q_o,
  input wire logic q_oe_n,
  input wire logic q_valid,
  input wire logic standby
);
  logic [22:0] op_n_q;
  logic [22:0] sb_n_q;
  default clocking @(posedge mclk); endclocking
  default disable iff (srst);
  always_ff @(posedge mclk)
    op_n_q <= (srst || !sense_en) ? 23'h0 : op_n_q + 23'h1;
  always_ff @(posedge mclk)
    sb_n_q <= (srst || !standby) ? 23'h0 : sb_n_q + 23'h1;
  a_op_len: assert property ($fell(sense_en) |-> op_n_q == 23'(dfs_pkg::OP_CYCLES)) else $error("op len");
  a_stb_len: assert property ($fell(standby) |-> sb_n_q == 23'(STB_CYCLES)) else $error("stb len");
  a_phase_order: assert property ($fell(sense_en) |-> standby) else $error("order");
  a_no_overlap: assert property (!(sense_en && standby)) else $error("overlap");
  a_oe_at_end: assert property ($changed(q_oe_n) |-> $rose(standby)) else $error("oe move");
  a_valid_held: assert property (q_valid |=> q_valid) else $error("valid drop");
  a_valid_at_end: assert property ($rose(q_valid) |-> $rose(standby)) else $error("valid time");
  a_drain_only: assert property (q_o == 1'b0) else $error("q_o high");
  c_stb: cover property ($rose(standby));
  c_sink: cover property ($fell(q_oe_n));
  c_valid: cover property ($rose(q_valid));
endmodule

// ===== sim/dfs_host_model.sv
`timescale 1ns/10ps
module dfs_host_model (
  input wire logic q_o,
  input wire logic q_oe_n,
  output logic pin
);
  // pull-up while the drain is off
  assign pin = q_oe_n ? 1'b1 : q_o;
endmodule

// ===== sim/duty_cycled_field_switch_seq_tb_top.sv
`timescale 1ns/10ps
module duty_cycled_field_switch_seq_tb_top;
  logic mclk = 1'b0;
  logic srst = 1'b1;
  logic supply_ok = 1'b0;
  logic polarity_select = 1'b1;
  logic [3:0] fld = 4'h3;
  logic sense_en, q_o, q_oe_n, q_valid, standby, pin;
  int error_cnt = 0;
  int comparisons = 0;
  dfs_seq #(.STB_CYCLES(200)) dfs_seq_i (.mclk(mclk), .srst(srst), .supply_ok(supply_ok),
    .polarity_select(polarity_select), .op_south(fld[3]), .op_north(fld[2]), .rel_south(fld[1]),
    .rel_north(fld[0]), .sense_en(sense_en), .q_o(q_o), .q_oe_n(q_oe_n), .q_valid(q_valid), .standby(standby));
  dfs_host_model dfs_host_model_i (.q_o(q_o), .q_oe_n(q_oe_n), .pin(pin));
  initial
  begin
    forever #20 mclk = ~mclk;
  end
  task automatic chk(input string what, input logic e, input logic s);
    comparisons++;
    if (s !== e)
    begin
      error_cnt++;
      $display("CHECK FAILED %s expected %b seen %b", what, e, s);
    end
  endtask
  task automatic clk(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic rst(input logic sel, input logic sup);
    srst = 1'b1;
    polarity_select = sel;
    supply_ok = 1'b0;
    clk(5);
    srst = 1'b0;
    supply_ok = sup;
  endtask
  task automatic phase(input logic [3:0] f);
    fld = f;
    while (standby === 1'b1) clk(1);
    while (standby !== 1'b1) clk(1);
    clk(2);
  endtask
  task automatic t_mode(input logic sel);
    logic [3:0] f [6] = '{4'h3, 4'h8, 4'h0, 4'h3, 4'h4, 4'h3};
    logic [5:0] sw = 6'h16;
    rst(sel, 1'b1);
    for (int i = 0; i < 6; i++)
    begin
      phase(f[i]);
      chk("pin", sel ^ sw[i], pin);
      chk("q_valid", 1'b1, q_valid);
    end
    $display("mode test done sel=%b", sel);
  endtask
  task automatic t_slow();
    rst(1'b1, 1'b0);
    clk(320);
    supply_ok = 1'b1;
    phase(4'h3);
    chk("q_valid first", 1'b0, q_valid);
    phase(4'h3);
    chk("q_valid second", 1'b1, q_valid);
    $display("slow start test done");
  endtask
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial
  begin
    t_mode(1'b1);
    t_mode(1'b0);
    t_slow();
    end_sim();
  end
  initial
  begin
    #1600000;
    error_cnt++;
    end_sim();
  end
endmodule
bind dfs_seq dfs_seq_properties #(.STB_CYCLES(STB_CYCLES)) dfs_seq_properties_i (.mclk(mclk), .srst(srst),
  .sense_en(sense_en), .q_o(q_o), .q_oe_n(q_oe_n), .q_valid(q_valid), .standby(standby));
